/* File: fmpc_pkg.sv */
package fmpc_pkg;
    // Register indices on the device's internal register port
    localparam logic [7:0] ADDR_LED_CHOICE = 8'h3f;
    localparam logic [7:0] ADDR_FLOAT_CTRL_B = 8'h59;
    localparam logic [7:0] ADDR_PULSE_MASK = 8'h5a;
    localparam logic [7:0] ADDR_FLOAT_CTRL_A = 8'h5e;

    // Reset values, reserved bits included
    localparam logic [15:0] RST_FLOAT_CTRL = 16'h0808;
    localparam logic [15:0] RST_PULSE_MASK = 16'h0010;
    localparam logic [1:0] RST_LED_CHOICE = 2'h0;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // Field positions
    localparam int EN_LSB = 13;
    localparam int EN_MSB = 14;
    localparam int PRECON_LSB = 8;
    localparam int PRECON_MSB = 12;
    localparam int MASK_B_LSB = 12;
    localparam int MASK_A_LSB = 8;
    localparam int CHOICE_LSB = 14;
    localparam int CHOICE_MSB = 15;

    // Float enable codes; 1 and 2 are reserved and leave float off
    localparam logic [1:0] FLOAT_OFF = 2'h0;
    localparam logic [1:0] FLOAT_ON = 2'h3;
    localparam logic [4:0] RST_PRECON = 5'h08;

    // Register port request, from the serial interface logic on sys_clk
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } fmpc_req_t;

    // Pulse query from the LED sequencer on sys_clk
    typedef struct packed {
        logic req;
        logic slot_b;
        logic [1:0] pos;
    } fmpc_pulse_t;

    typedef struct packed {
        logic [15:0] ctrl_b;
        logic [15:0] mask;
        logic [15:0] ctrl_a;
        logic [1:0] choice_b;
        logic [15:0] rdata;
        logic fire;
        logic fire_valid;
        logic float_b;
        logic float_a;
    } fmpc_state_t;
endpackage

/* File: fmpc_top.sv */
`timescale 1ns/1ps
// How it works
// - Slot B float on only for code 3
// - Slot A float on only for code 3
// - Slot B precondition field, resets to 8
// - Slot A precondition field, resets to 8
// - Mask bit 0 fires LED, 1 suppresses
// - Slot B mask bits 15..12, pulse order
// - Slot A mask bits 11..8, reset zero
// - Slot B float LED choice, 0 none
module fmpc_top
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port
    input wire fmpc_pkg::fmpc_req_t reg_req,
    output logic [15:0] reg_rdata,
    // Pulse query from the sequencer
    input wire fmpc_pkg::fmpc_pulse_t pulse,
    output logic led_fire,
    output logic led_fire_valid,
    // Configuration to the timing core
    output logic float_on_slot_a,
    output logic float_on_slot_b,
    output logic [4:0] precondition_delay_slot_a,
    output logic [4:0] precondition_delay_slot_b,
    output logic [3:0] pulse_mask_slot_a,
    output logic [3:0] pulse_mask_slot_b,
    output logic [1:0] led_choice_slot_b
);
    fmpc_pkg::fmpc_state_t state;
    fmpc_pkg::fmpc_state_t next_state;

    // Reserved codes must not enable float, so only the full code counts
    function automatic logic float_code_on(input logic [15:0] ctrl);
        return ctrl[fmpc_pkg::EN_MSB:fmpc_pkg::EN_LSB] == fmpc_pkg::FLOAT_ON;
    endfunction

    function automatic logic [3:0] slot_mask(input logic [15:0] mask, input logic slot_b);
        if (slot_b)
        begin
            return mask[fmpc_pkg::MASK_B_LSB +: 4];
        end
        else
        begin
            return mask[fmpc_pkg::MASK_A_LSB +: 4];
        end
    endfunction

    always_comb
    begin
        logic [3:0] sel_mask;
        sel_mask = 4'h0;
        next_state = state;
        // Reserved bits of the control and mask registers are stored as written (LED choice keeps only bits 15..14); software keeps them at their values
        if (reg_req.wr)
        begin
            if (reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_B)
            begin
                next_state.ctrl_b = reg_req.wdata;
            end
            else if (reg_req.addr == fmpc_pkg::ADDR_PULSE_MASK)
            begin
                next_state.mask = reg_req.wdata;
            end
            else if (reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_A)
            begin
                next_state.ctrl_a = reg_req.wdata;
            end
            else if (reg_req.addr == fmpc_pkg::ADDR_LED_CHOICE)
            begin
                next_state.choice_b = reg_req.wdata[fmpc_pkg::CHOICE_MSB:fmpc_pkg::CHOICE_LSB];
            end
        end
        // Read data holds until the next read; unmapped indices read zero
        if (reg_req.rd)
        begin
            if (reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_B)
            begin
                next_state.rdata = state.ctrl_b;
            end
            else if (reg_req.addr == fmpc_pkg::ADDR_PULSE_MASK)
            begin
                next_state.rdata = state.mask;
            end
            else if (reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_A)
            begin
                next_state.rdata = state.ctrl_a;
            end
            else if (reg_req.addr == fmpc_pkg::ADDR_LED_CHOICE)
            begin
                next_state.rdata = {state.choice_b, 14'h0000};
            end
            else
            begin
                next_state.rdata = fmpc_pkg::READ_ZERO;
            end
        end
        // Pulse position wraps every four pulses, so the sequencer sends pos modulo 4
        next_state.fire_valid = pulse.req;
        if (pulse.req)
        begin
            sel_mask = slot_mask(state.mask, pulse.slot_b);
            next_state.fire = ~sel_mask[pulse.pos];
        end
        next_state.float_b = float_code_on(next_state.ctrl_b);
        next_state.float_a = float_code_on(next_state.ctrl_a);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            state.ctrl_b <= fmpc_pkg::RST_FLOAT_CTRL;
            state.mask <= fmpc_pkg::RST_PULSE_MASK;
            state.ctrl_a <= fmpc_pkg::RST_FLOAT_CTRL;
            state.choice_b <= fmpc_pkg::RST_LED_CHOICE;
            state.rdata <= fmpc_pkg::READ_ZERO;
            state.fire <= 1'b0;
            state.fire_valid <= 1'b0;
            state.float_b <= 1'b0;
            state.float_a <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign led_fire = state.fire;
    assign led_fire_valid = state.fire_valid;
    assign float_on_slot_a = state.float_a;
    assign float_on_slot_b = state.float_b;
    assign precondition_delay_slot_a = state.ctrl_a[fmpc_pkg::PRECON_MSB:fmpc_pkg::PRECON_LSB];
    assign precondition_delay_slot_b = state.ctrl_b[fmpc_pkg::PRECON_MSB:fmpc_pkg::PRECON_LSB];
    assign pulse_mask_slot_a = state.mask[fmpc_pkg::MASK_A_LSB +: 4];
    assign pulse_mask_slot_b = state.mask[fmpc_pkg::MASK_B_LSB +: 4];
    assign led_choice_slot_b = state.choice_b;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // Reserved codes read back as written but never enable float
    a_float_b_code: assert property (reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_B |=>
        float_on_slot_b == ($past(reg_req.wdata[fmpc_pkg::EN_MSB:fmpc_pkg::EN_LSB]) == fmpc_pkg::FLOAT_ON))
        else $error("slot B float state wrong after write");
    a_float_a_write: assert property (reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_A |=>
        float_on_slot_a == ($past(reg_req.wdata[fmpc_pkg::EN_MSB:fmpc_pkg::EN_LSB]) == fmpc_pkg::FLOAT_ON))
        else $error("slot A float state wrong after write");
    a_float_reset_off: assert property (!$past(rst_b) |-> !float_on_slot_a && !float_on_slot_b)
        else $error("float mode on after reset");
    a_float_b_hold: assert property (!(reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_B) |=>
        $stable(float_on_slot_b) && $stable(precondition_delay_slot_b))
        else $error("slot B control changed without a write");
    a_float_a_hold: assert property (!(reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_A) |=>
        $stable(float_on_slot_a) && $stable(precondition_delay_slot_a))
        else $error("slot A control changed without a write");

    a_precon_b_reset: assert property (!$past(rst_b) |-> precondition_delay_slot_b == fmpc_pkg::RST_PRECON)
        else $error("slot B precondition not 8 after reset");
    a_precon_a_reset: assert property (!$past(rst_b) |-> precondition_delay_slot_a == fmpc_pkg::RST_PRECON)
        else $error("slot A precondition not 8 after reset");
    a_precon_b_write: assert property (reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_B |=>
        precondition_delay_slot_b == $past(reg_req.wdata[fmpc_pkg::PRECON_MSB:fmpc_pkg::PRECON_LSB]))
        else $error("slot B precondition not taken from write");
    a_precon_a_write: assert property (reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_A |=>
        precondition_delay_slot_a == $past(reg_req.wdata[fmpc_pkg::PRECON_MSB:fmpc_pkg::PRECON_LSB]))
        else $error("slot A precondition not taken from write");

    // The decision uses the mask held before the query edge
    a_fire_slot_b: assert property (pulse.req && pulse.slot_b |=>
        led_fire_valid && led_fire == !$past(state.mask[fmpc_pkg::MASK_B_LSB + pulse.pos]))
        else $error("slot B fire decision wrong");
    a_fire_slot_a: assert property (pulse.req && !pulse.slot_b |=>
        led_fire_valid && led_fire == !$past(state.mask[fmpc_pkg::MASK_A_LSB + pulse.pos]))
        else $error("slot A fire decision wrong");
    a_fire_valid_once: assert property (!pulse.req |=> !led_fire_valid)
        else $error("fire decision flagged without a query");
    a_fire_hold: assert property (!pulse.req |=> $stable(led_fire))
        else $error("fire decision changed without a query");

    a_mask_reset_zero: assert property (!$past(rst_b) |->
        pulse_mask_slot_a == 4'h0 && pulse_mask_slot_b == 4'h0)
        else $error("pulse masks not zero after reset");
    a_mask_b_write: assert property (reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_PULSE_MASK |=>
        pulse_mask_slot_b == $past(reg_req.wdata[fmpc_pkg::MASK_B_LSB +: 4]))
        else $error("slot B mask not taken from write");
    a_mask_a_write: assert property (reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_PULSE_MASK |=>
        pulse_mask_slot_a == $past(reg_req.wdata[fmpc_pkg::MASK_A_LSB +: 4]))
        else $error("slot A mask not taken from write");
    a_mask_hold: assert property (!(reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_PULSE_MASK) |=>
        $stable(pulse_mask_slot_a) && $stable(pulse_mask_slot_b))
        else $error("masks changed without a write");

    a_choice_b_write: assert property (reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_LED_CHOICE |=>
        led_choice_slot_b == $past(reg_req.wdata[fmpc_pkg::CHOICE_MSB:fmpc_pkg::CHOICE_LSB]))
        else $error("slot B LED choice not updated");
    a_choice_reset: assert property (!$past(rst_b) |-> led_choice_slot_b == fmpc_pkg::RST_LED_CHOICE)
        else $error("slot B LED choice not zero after reset");
    a_choice_hold: assert property (!(reg_req.wr && reg_req.addr == fmpc_pkg::ADDR_LED_CHOICE) |=>
        $stable(led_choice_slot_b))
        else $error("slot B LED choice changed without a write");

    // A read in the cycle of a write to the same index returns the old value
    a_read_ctrl_b: assert property (reg_req.rd && reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_B |=>
        reg_rdata == $past(state.ctrl_b))
        else $error("slot B control read data wrong");
    a_read_ctrl_a: assert property (reg_req.rd && reg_req.addr == fmpc_pkg::ADDR_FLOAT_CTRL_A |=>
        reg_rdata == $past(state.ctrl_a))
        else $error("slot A control read data wrong");
    a_read_mask_data: assert property (reg_req.rd && reg_req.addr == fmpc_pkg::ADDR_PULSE_MASK |=>
        reg_rdata == $past(state.mask))
        else $error("mask read data wrong");
    a_read_choice: assert property (reg_req.rd && reg_req.addr == fmpc_pkg::ADDR_LED_CHOICE |=>
        reg_rdata == {$past(led_choice_slot_b), 14'h0000})
        else $error("LED choice read data wrong");
    a_read_unmapped: assert property (reg_req.rd && reg_req.addr != fmpc_pkg::ADDR_FLOAT_CTRL_B
        && reg_req.addr != fmpc_pkg::ADDR_PULSE_MASK && reg_req.addr != fmpc_pkg::ADDR_FLOAT_CTRL_A
        && reg_req.addr != fmpc_pkg::ADDR_LED_CHOICE |=> reg_rdata == fmpc_pkg::READ_ZERO)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_outputs_reset: assert property (!$past(rst_b) |->
        reg_rdata == fmpc_pkg::READ_ZERO && !led_fire_valid && !led_fire)
        else $error("read data or fire outputs not cleared by reset");
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic sys_clk;
    logic rst_b;
    fmpc_pkg::fmpc_req_t reg_req;
    fmpc_pkg::fmpc_pulse_t pulse;
    logic [15:0] rdata;
    logic fire, fire_v, fl_a, fl_b;
    logic [4:0] pc_a, pc_b;
    logic [3:0] mk_a, mk_b;
    logic [1:0] choice;
    int n_errors;
    int n_checks;
    fmpc_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(rdata), .pulse(pulse),
        .led_fire(fire), .led_fire_valid(fire_v), .float_on_slot_a(fl_a), .float_on_slot_b(fl_b),
        .precondition_delay_slot_a(pc_a), .precondition_delay_slot_b(pc_b), .pulse_mask_slot_a(mk_a),
        .pulse_mask_slot_b(mk_b), .led_choice_slot_b(choice));
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Strobes last one cycle; outputs land on the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk) reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk) reg_req <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk) reg_req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge sys_clk) reg_req <= '0;
        #1 chk("reg_rdata", e, rdata);
    endtask
    task automatic ask(input logic sb, input logic [1:0] p, input logic e);
        @(posedge sys_clk) pulse <= '{1'b1, sb, p};
        @(posedge sys_clk) pulse <= '0;
        #1 chk("led_fire_valid", 16'h0001, {15'h0, fire_v});
        chk("led_fire", {15'h0, e}, {15'h0, fire});
        @(posedge sys_clk) #1 chk("led_fire_valid", 16'h0000, {15'h0, fire_v});
        chk("led_fire_hold", {15'h0, e}, {15'h0, fire});
    endtask
    task automatic t_reset;
        chk("float_on", 16'h0000, {14'h0, fl_a, fl_b});
        chk("precon_a", 16'h0008, {11'h0, pc_a});
        chk("precon_b", 16'h0008, {11'h0, pc_b});
        chk("masks", 16'h0000, {8'h0, mk_b, mk_a});
        rd(8'h59, 16'h0808);
        rd(8'h5a, 16'h0010);
        rd(8'h5e, 16'h0808);
        rd(8'h3f, 16'h0000);
    endtask
    // Reserved codes must leave float off even though they read back
    task automatic t_enable;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h59, {1'b0, c[1:0], 13'h0808});
            chk("float_on_slot_b", {15'h0, c == 3}, {15'h0, fl_b});
            wr(8'h5e, {1'b0, c[1:0], 13'h0808});
            chk("float_on_slot_a", {15'h0, c == 3}, {15'h0, fl_a});
            rd(8'h5e, {1'b0, c[1:0], 13'h0808});
        end
    endtask
    task automatic t_precon;
        wr(8'h59, 16'h1f08);
        chk("precon_b", 16'h001f, {11'h0, pc_b});
        wr(8'h5e, 16'h6008);
        chk("precon_a", 16'h0000, {11'h0, pc_a});
        chk("float_on_slot_a", 16'h0001, {15'h0, fl_a});
    endtask
    // One suppressed slot B position walks through the group of four; slot A gets the inverse
    task automatic t_mask;
        logic [3:0] m;
        for (int i = 0; i < 4; i++)
        begin
            m = 4'h1 << i;
            wr(8'h5a, {m, ~m, 8'h10});
            chk("mask_b", {12'h0, m}, {12'h0, mk_b});
            chk("mask_a", {12'h0, ~m}, {12'h0, mk_a});
            for (int p = 0; p < 4; p++)
            begin
                ask(1'b1, p[1:0], p != i);
                ask(1'b0, p[1:0], p == i);
            end
        end
    endtask
    task automatic t_choice;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h3f, {c[1:0], 14'h0});
            chk("led_choice", {14'h0, c[1:0]}, {14'h0, choice});
            rd(8'h3f, {c[1:0], 14'h0});
        end
    endtask
    task automatic t_unmapped;
        wr(8'h5b, 16'hffff);
        rd(8'h5b, 16'h0000);
        rd(8'h5a, 16'h8710);
    endtask
    // Reset in mid-run must undo every write, not only match the power-up state
    task automatic t_rerun;
        @(posedge sys_clk) rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        t_reset();
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        rst_b = 1'b0;
        reg_req = '0;
        pulse = '0;
        n_errors = 0;
        n_checks = 0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        t_reset();
        t_enable();
        t_precon();
        t_mask();
        t_choice();
        t_unmapped();
        t_rerun();
        end_of_test();
    end
endmodule
